// >>> logic/fasu_top.sv
// Purpose: floating add/subtract datapath with apb register access
// Assumes: new operand written to the new-operand registers before start
// Notes: primary fraction a, secondary fraction b, 48 bits with bit 47 as sign slot
`timescale 1ns/1ps
module fasu_top
   import fasu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   typedef struct packed {
      fasu_state_e st;
      logic [47:0] a; // primary fraction
      logic [47:0] b; // secondary fraction
      logic [7:0] e; // result exponent
      logic acc_sign_flag;
      logic new_sign_flag;
      logic exponent_compare_flag;
      logic eq_exp;
      logic sub_op;
      logic [7:0] ne; // new operand exponent latch
      logic [47:0] nf; // new operand fraction latch
      logic new_sign;
      logic [31:0] rdata;
      logic err;
      logic [INT_N-1:0] evt;
   } fasu_s;
   fasu_s r, next_r;

   logic setup;
   logic wr;
   logic sc_load;
   logic [7:0] sc_value;
   logic sc_dec;
   logic [7:0] sc_count;
   logic sc_zero;
   logic sc_skip;
   logic [INT_N-1:0] int_status;
   logic [INT_N-1:0] int_enable;
   logic int_clear_we;
   logic int_enable_we;
   logic [8:0] exp_diff;
   logic [47:0] sum;
   logic [47:0] diff;

   // address decode for known registers
   function automatic logic is_mapped(input logic [7:0] addr);
      case (addr)
         OFS_CTRL, OFS_STATUS, OFS_ACC_EXP, OFS_ACC_FRAC_LO, OFS_ACC_FRAC_HI,
         OFS_NEW_EXP, OFS_NEW_FRAC_LO, OFS_NEW_FRAC_HI, OFS_INT_STATUS,
         OFS_INT_ENABLE, OFS_INT_CLEAR, OFS_SEC_FRAC_LO, OFS_SEC_FRAC_HI: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // apb phases: data registered in setup, answered in access
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && !r.err;
   assign pready = 1'b1;
   assign pslverr = psel && penable && r.err;
   assign prdata = r.rdata;
   assign int_clear_we = wr && (paddr == OFS_INT_CLEAR);
   assign int_enable_we = wr && (paddr == OFS_INT_ENABLE);

   // arithmetic helpers
   assign exp_diff = {1'b0, r.e} - {1'b0, r.ne}; // [RULE_16]
   assign sum = r.a + r.b; // [RULE_04]
   assign diff = r.a - r.b; // [RULE_04]

   fasu_shift_counter u_sc (
      .pclk(pclk),
      .presetn(presetn),
      .load(sc_load),
      .load_value(sc_value),
      .dec(sc_dec),
      .count(sc_count),
      .is_zero(sc_zero),
      .skip(sc_skip)
   );

   fasu_irq #(.N(INT_N)) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .event_set(r.evt),
      .clear_we(int_clear_we),
      .enable_we(int_enable_we),
      .wdata(pwdata[INT_N-1:0]),
      .status(int_status),
      .enable(int_enable),
      .irq(irq)
   );

   // shift counter control
   always_comb begin
      sc_load = (r.st == FASU_COMPARE);
      sc_value = exp_diff[8] ? (8'h00 - exp_diff[7:0]) : exp_diff[7:0]; // [RULE_02]
      sc_dec = (r.st == FASU_ALIGN) && !sc_zero; // [RULE_18]
   end

   // sequencer, datapath and register writes
   always_comb begin
      next_r = r;
      next_r.evt = '0;
      if (setup) begin
         next_r.err = !is_mapped(paddr);
         case (paddr)
            OFS_STATUS: next_r.rdata = {23'h0, r.st, r.exponent_compare_flag, r.st != FASU_IDLE};
            OFS_ACC_EXP: next_r.rdata = {23'h0, r.acc_sign_flag, r.e};
            OFS_ACC_FRAC_LO: next_r.rdata = r.a[31:0];
            OFS_ACC_FRAC_HI: next_r.rdata = {16'h0, r.a[47:32]};
            OFS_NEW_EXP: next_r.rdata = {23'h0, r.new_sign, r.ne};
            OFS_NEW_FRAC_LO: next_r.rdata = r.nf[31:0];
            OFS_NEW_FRAC_HI: next_r.rdata = {16'h0, r.nf[47:32]};
            OFS_INT_STATUS: next_r.rdata = {{(32-INT_N){1'b0}}, int_status};
            OFS_INT_ENABLE: next_r.rdata = {{(32-INT_N){1'b0}}, int_enable};
            OFS_SEC_FRAC_LO: next_r.rdata = r.b[31:0];
            OFS_SEC_FRAC_HI: next_r.rdata = {16'h0, r.b[47:32]};
            default: next_r.rdata = 32'h0;
         endcase
      end
      // operand and accumulator loads only while idle
      if (wr && r.st == FASU_IDLE) begin
         case (paddr)
            OFS_ACC_EXP: begin
               next_r.e = pwdata[7:0]; // [RULE_15]
               next_r.acc_sign_flag = pwdata[EXP_SIGN_BIT];
            end
            OFS_ACC_FRAC_LO: begin
               next_r.a[31:0] = pwdata;
               next_r.b[31:0] = pwdata;
            end
            OFS_ACC_FRAC_HI: begin
               next_r.a[47:32] = pwdata[15:0];
               next_r.b[47:32] = pwdata[15:0];
            end
            OFS_NEW_EXP: begin
               next_r.ne = pwdata[7:0]; // [RULE_15]
               next_r.new_sign = pwdata[EXP_SIGN_BIT];
            end
            OFS_NEW_FRAC_LO: next_r.nf[31:0] = pwdata;
            OFS_NEW_FRAC_HI: next_r.nf[47:32] = pwdata[15:0];
            OFS_CTRL: begin
               if (pwdata[CTRL_START_BIT]) begin
                  next_r.sub_op = pwdata[CTRL_SUB_BIT];
                  next_r.new_sign_flag = r.new_sign ^ pwdata[CTRL_SUB_BIT]; // [RULE_01]
                  next_r.st = FASU_COMPARE;
               end
            end
            default: ;
         endcase
      end
      case (r.st)
         FASU_IDLE: ;
         FASU_COMPARE: begin
            next_r.exponent_compare_flag = !exp_diff[8]; // [RULE_16]
            next_r.eq_exp = (exp_diff == 9'h000);
            if (exp_diff[8]) begin
               // new operand larger: it becomes primary, old stays in b
               next_r.a = r.nf; // [RULE_12] [RULE_05]
               next_r.e = r.ne;
               next_r.acc_sign_flag = r.new_sign_flag; // [RULE_12]
               next_r.new_sign_flag = r.acc_sign_flag;
            end else begin
               next_r.b = r.nf; // [RULE_05] [RULE_13]
            end
            next_r.st = FASU_CHECK;
         end
         FASU_CHECK: begin
            if (sc_skip) begin
               next_r.st = FASU_FINISH; // [RULE_03]
            end else begin
               next_r.st = FASU_ALIGN;
            end
         end
         FASU_ALIGN: begin
            if (sc_zero) begin
               next_r.st = FASU_COMBINE;
            end else begin
               next_r.b = {1'b0, r.b[47:1]}; // [RULE_02] [RULE_18]
            end
         end
         FASU_COMBINE: begin
            if (r.acc_sign_flag == r.new_sign_flag) begin
               // sign flag untouched when signs agree, except a zero sum clears it
               if (sum[47]) begin // [RULE_11]
                  if (r.e == EXP_MAX) begin
                     next_r.a = FRAC_MAX; // [RULE_10]
                     next_r.evt[INT_OVF_BIT] = 1'b1; // [RULE_10]
                     next_r.st = FASU_FINISH;
                  end else begin
                     next_r.a = {1'b0, sum[47:1]}; // [RULE_09]
                     next_r.e = r.e + 8'h01; // [RULE_09]
                     next_r.st = FASU_FINISH;
                  end
               end else begin
                  next_r.a = sum;
                  if (sum == 48'h0) begin
                     // zero sum takes the all-zero format
                     next_r.e = EXP_RESET;
                     next_r.acc_sign_flag = 1'b0;
                     next_r.st = FASU_FINISH;
                  end else begin
                     next_r.st = FASU_NORM;
                  end
               end
            end else begin
               if (r.eq_exp && diff[47]) begin
                  next_r.a = 48'h0 - diff; // [RULE_06]
                  next_r.acc_sign_flag = !r.acc_sign_flag; // [RULE_14]
               end else begin
                  next_r.a = diff;
               end
               if (diff == 48'h0) begin
                  // exact cancellation gives the zero format
                  next_r.e = EXP_RESET;
                  next_r.acc_sign_flag = 1'b0;
                  next_r.st = FASU_FINISH;
               end else begin
                  next_r.st = FASU_NORM;
               end
            end
         end
         FASU_NORM: begin
            if (r.a[46]) begin
               next_r.st = FASU_FINISH;
            end else if (r.e == EXP_MIN) begin
               // decrement would wrap to FF: underflow branch
               next_r.a = 48'h0; // [RULE_08]
               next_r.e = EXP_RESET;
               next_r.acc_sign_flag = 1'b0;
               next_r.evt[INT_UNF_BIT] = 1'b1; // [RULE_08]
               next_r.st = FASU_FINISH;
            end else begin
               next_r.a = {r.a[46:0], 1'b0}; // [RULE_07]
               next_r.e = r.e - 8'h01; // [RULE_07]
            end
         end
         FASU_FINISH: begin
            next_r.b = r.a; // [RULE_19]
            next_r.evt[INT_DONE_BIT] = 1'b1;
            next_r.st = FASU_IDLE;
         end
         default: next_r.st = FASU_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{st: FASU_IDLE, e: EXP_RESET, ne: EXP_RESET, default: '0};
      end else begin
         r <= next_r;
      end
   end
endmodule

// >>> pkg/fasu_pkg.sv
// Purpose: constants and types shared by the float add/subtract unit
// Assumes: apb register map with 32-bit aligned words
// Notes: fractions are 48 bits, bit 47 is the sign/overflow position
//
// Contract
// RULE_01: subtract inverts the new operand sign as it enters new_sign_flag; otherwise like add.
// RULE_02: unequal exponents: smaller fraction shifts right by the exponent difference.
// RULE_03: difference 23 or more skips alignment and arithmetic, larger operand is result.
// RULE_04: below threshold, add fractions when signs agree, subtract when they differ.
// RULE_05: smaller fraction always sits in the secondary fraction register.
// RULE_06: equal exponents subtraction: a negative difference is complemented to magnitude.
// RULE_07: normalize by left shifts until bit 46 is one, exponent down per shift.
// RULE_08: exponent decrement from 00 to FF forces zero result and raises interrupt flag.
// RULE_09: same-sign sum carrying into bit 47 shifts right once, exponent up.
// RULE_10: exponent increment reaching 256 with overflowed fraction gives max magnitude and interrupt.
// RULE_11: equal signs keep the accumulator sign flag as result sign; the code clears it when the sum is zero.
// RULE_12: larger new exponent loads new fraction into primary register and swaps sign flags.
// RULE_13: differing signs, smaller new operand: result sign is the starting accumulator sign.
// RULE_14: equal exponents, negative difference inverts the accumulator sign flag.
// RULE_15: exponents are 8-bit excess-128 codes.
// RULE_16: shift counter gets result minus new exponent; flag set when new is not larger.
// RULE_17: skip test adds two's complement of 23 to shift count, carry is flag.
// RULE_18: alignment shifts one place per clock, decrementing shift counter to zero.
// RULE_19: result leaves same fraction in both registers, exponent and sign in place.
package fasu_pkg;
   localparam int FRAC_W = 48;
   localparam int EXP_W = 8;
   localparam logic [7:0] EXP_BIAS = 8'h80; // excess-128 zero point
   localparam logic [7:0] SKIP_THRESHOLD = 8'h17; // 23 places
   localparam logic [7:0] EXP_MAX = 8'hFF;
   localparam logic [7:0] EXP_MIN = 8'h00;
   localparam logic [47:0] FRAC_MAX = 48'h7FFF_FFFF_FFFF;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ACC_EXP = 8'h08;
   localparam logic [7:0] OFS_ACC_FRAC_LO = 8'h0C;
   localparam logic [7:0] OFS_ACC_FRAC_HI = 8'h10;
   localparam logic [7:0] OFS_NEW_EXP = 8'h14;
   localparam logic [7:0] OFS_NEW_FRAC_LO = 8'h18;
   localparam logic [7:0] OFS_NEW_FRAC_HI = 8'h1C;
   localparam logic [7:0] OFS_INT_STATUS = 8'h20;
   localparam logic [7:0] OFS_INT_ENABLE = 8'h24;
   localparam logic [7:0] OFS_INT_CLEAR = 8'h28;
   localparam logic [7:0] OFS_SEC_FRAC_LO = 8'h2C;
   localparam logic [7:0] OFS_SEC_FRAC_HI = 8'h30;
   // field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_SUB_BIT = 1;
   localparam int EXP_SIGN_BIT = 8;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_OVF_BIT = 1;
   localparam int INT_UNF_BIT = 2;
   localparam int INT_N = 3;
   localparam logic [2:0] INT_ENABLE_RESET = 3'h0;
   localparam logic [7:0] EXP_RESET = 8'h00;

   typedef enum logic [6:0] {
      FASU_IDLE = 7'h01,
      FASU_COMPARE = 7'h02,
      FASU_CHECK = 7'h04,
      FASU_ALIGN = 7'h08,
      FASU_COMBINE = 7'h10,
      FASU_NORM = 7'h20,
      FASU_FINISH = 7'h40
   } fasu_state_e;
endpackage

// >>> logic/fasu_shift_counter.sv
// Purpose: alignment shift counter with zero and skip-threshold flags
// Assumes: load and decrement never asserted together
// Notes: skip flag is the carry of count plus the two's complement of 23
`timescale 1ns/1ps
module fasu_shift_counter
   import fasu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [7:0] load_value,
   input wire logic dec,
   output logic [7:0] count,
   output logic is_zero,
   output logic skip
);
   typedef struct packed {
      logic [7:0] cnt;
   } fasu_sc_s;
   fasu_sc_s r, next_r;
   logic [8:0] thr_sum;

   // threshold test by carry out
   assign thr_sum = {1'b0, r.cnt} + {1'b0, (~SKIP_THRESHOLD + 8'h01)}; // [RULE_17]
   assign skip = thr_sum[8];
   assign is_zero = (r.cnt == 8'h00);
   assign count = r.cnt;

   // load or count down one per clock
   always_comb begin
      next_r = r;
      if (load) begin
         next_r.cnt = load_value;
      end else if (dec && !is_zero) begin
         next_r.cnt = r.cnt - 8'h01; // [RULE_18]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

// >>> logic/fasu_irq.sv
// Purpose: sticky event status, enable mask and level interrupt
// Assumes: clear is write-one-to-clear, one cycle strobe
// Notes: an event in the clear cycle stays set
`timescale 1ns/1ps
module fasu_irq
   import fasu_pkg::*;
#(
   parameter int N = INT_N
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] event_set,
   input wire logic clear_we,
   input wire logic enable_we,
   input wire logic [N-1:0] wdata,
   output logic [N-1:0] status,
   output logic [N-1:0] enable,
   output logic irq
);
   typedef struct packed {
      logic [N-1:0] st;
      logic [N-1:0] en;
   } fasu_irq_s;
   fasu_irq_s r, next_r;

   initial begin
      if (N < 1 || N > 32) $error("fasu_irq: N out of range");
   end

   // set wins over clear
   always_comb begin
      next_r = r;
      if (clear_we) begin
         next_r.st = r.st & ~wdata;
      end
      next_r.st = next_r.st | event_set;
      if (enable_we) begin
         next_r.en = wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{st: '0, en: N'(INT_ENABLE_RESET)};
      end else begin
         r <= next_r;
      end
   end

   assign status = r.st;
   assign enable = r.en;
   assign irq = |(r.st & r.en);
endmodule

// >>> tb/fasu_top_asserts.sv
// Purpose: pin-level checks for the float add/subtract unit
// Assumes: zero wait-state apb answers
// Notes: only relations seen at the apb and irq pins
`timescale 1ns/1ps
module fasu_top_asserts
   import fasu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq
);
   logic acc;
   logic rd;
   logic mapped;
   // access phase and address decode
   assign acc = psel && penable;
   assign rd = acc && !pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_SEC_FRAC_HI);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_access: assert property (psel && !penable ##1 penable |-> pready)
      else $error("no ready in access phase");
   a_err_unmapped: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_err_mapped: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_wo_zero: assert property (rd && (paddr == OFS_CTRL || paddr == OFS_INT_CLEAR) |-> prdata == 32'h0)
      else $error("write-only register read not zero");
   a_state_shape: assert property (rd && paddr == OFS_STATUS |-> $onehot(prdata[8:2]) && prdata[0] == !prdata[2])
      else $error("status state field malformed");
   a_irq_masked: assert property (rd && paddr == OFS_INT_ENABLE && prdata[2:0] == 3'h0 |-> !irq)
      else $error("irq high with all sources masked");
   a_fault_done: assert property (rd && paddr == OFS_INT_STATUS && prdata[2:1] != 2'h0 |-> prdata[0])
      else $error("fault without done");
   a_exp_code: assert property (rd && paddr == OFS_ACC_EXP |-> prdata[31:9] == 23'h0)
      else $error("exponent register wider than code and sign");
   a_quiet_start: assert property ($rose(presetn) |-> !irq [*2])
      else $error("irq after reset");
endmodule

// >>> tb/fasu_cpu_model.sv
// Purpose: apb master standing in for the central processor
// Assumes: each transfer is started right after a rising edge
// Notes: address and data are scrambled once the bus is released
`timescale 1ns/1ps
module fasu_cpu_model
(
   input wire logic pclk,
   input wire logic pready,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // setup, access held until pready, release, one idle edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule

// >>> tb/fasu_top_tb_top.sv
// Purpose: self-checking bench for the float add/subtract unit
// Assumes: done interrupt marks the end of each operation
// Notes: expected results come from a bench-side reference
`timescale 1ns/1ps
module fasu_top_tb_top
   import fasu_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [32:0] exp_q[$];
   logic [63:0] rnd;
   int err_total;
   int comparisons;
   int seed;
   int cyc;
   int k;
   fasu_cpu_model cpu (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   fasu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   // clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task cmp(input logic [32:0] e, input logic [32:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task test_done;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d);
   endtask
   task rd_chk(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      cpu.xfer(1'b0, a, 32'h0);
   endtask
   task chk_irq(input logic e);
      @(negedge pclk);
      cmp({32'h0, e}, {32'h0, irq});
      @(posedge pclk);
   endtask
   // reference: {underflow, overflow, sign, exponent, fraction}
   function automatic logic [58:0] ref_op(input logic [8:0] ae, input logic [47:0] af, input logic [8:0] be,
      input logic [47:0] bf, input logic sub);
      logic as, bs, t;
      logic [7:0] e, d;
      logic [47:0] a, b, s;
      as = ae[8];
      bs = be[8] ^ sub;
      if (be[7:0] > ae[7:0]) begin
         e = be[7:0];
         d = be[7:0] - ae[7:0];
         a = bf;
         b = af;
         t = as;
         as = bs;
         bs = t;
      end else begin
         e = ae[7:0];
         d = ae[7:0] - be[7:0];
         a = af;
         b = bf;
      end
      if (d >= SKIP_THRESHOLD) return {2'b00, as, e, a};
      b = b >> d;
      s = (as == bs) ? a + b : a - b;
      if (as != bs && d == 8'h00 && s[47]) begin
         s = -s;
         as = ~as;
      end
      if (s == 48'h0) return 59'h0;
      if (s[47]) begin
         if (e == EXP_MAX) return {2'b01, as, e, FRAC_MAX};
         s = s >> 1;
         e++;
      end
      while (!s[46]) begin
         if (e == EXP_MIN) return {2'b10, 57'h0};
         s = s << 1;
         e--;
      end
      return {2'b00, as, e, s};
   endfunction
   // load operands, start, wait for done, mask, read back, clear
   task run(input logic [8:0] ae, input logic [47:0] af, input logic [8:0] be, input logic [47:0] bf,
      input logic sub);
      logic [58:0] r;
      int i;
      r = ref_op(ae, af, be, bf, sub);
      wr(OFS_ACC_EXP, {23'h0, ae});
      wr(OFS_ACC_FRAC_LO, af[31:0]);
      wr(OFS_ACC_FRAC_HI, {16'h0, af[47:32]});
      wr(OFS_NEW_EXP, {23'h0, be});
      wr(OFS_NEW_FRAC_LO, bf[31:0]);
      wr(OFS_NEW_FRAC_HI, {16'h0, bf[47:32]});
      wr(OFS_CTRL, {30'h0, sub, 1'b1});
      i = 0;
      while (irq !== 1'b1 && i < 300) begin
         @(negedge pclk);
         i++;
      end
      chk_irq(1'b1);
      wr(OFS_INT_ENABLE, 32'h0);
      chk_irq(1'b0);
      wr(OFS_INT_ENABLE, 32'h7);
      chk_irq(1'b1);
      rd_chk(OFS_ACC_EXP, {24'h0, r[56:48]});
      rd_chk(OFS_ACC_FRAC_LO, {1'b0, r[31:0]});
      rd_chk(OFS_ACC_FRAC_HI, {17'h0, r[47:32]});
      rd_chk(OFS_SEC_FRAC_LO, {1'b0, r[31:0]});
      rd_chk(OFS_SEC_FRAC_HI, {17'h0, r[47:32]});
      rd_chk(OFS_INT_STATUS, {30'h0, r[58:57], 1'b1});
      wr(OFS_INT_CLEAR, 32'h7);
      chk_irq(1'b0);
      $display("test done t=%0t", $time);
   endtask
   // read checker: oldest note against each completed read
   always @(posedge pclk) begin
      if (presetn && psel && penable && pready && !pwrite && exp_q.size() > 0)
         cmp(exp_q.pop_front(), {pslverr, prdata});
   end
   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         test_done;
      end
   end
   // main sequence
   initial begin
      presetn = 1'b0;
      seed = 49031;
      err_total = 0;
      comparisons = 0;
      cyc = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(OFS_STATUS, 33'h4);
      rd_chk(OFS_ACC_EXP, 33'h0);
      rd_chk(OFS_INT_ENABLE, 33'h0);
      rd_chk(OFS_CTRL, 33'h0);
      rd_chk(OFS_INT_CLEAR, 33'h0);
      rd_chk(8'h34, 33'h1_0000_0000);
      wr(OFS_INT_ENABLE, 32'h7);
      run(9'h083, 48'h7000_0000_0000, 9'h081, 48'h4000_0000_0000, 1'b0);
      run(9'h082, 48'h6000_0000_0000, 9'h185, 48'h4000_0000_0000, 1'b0);
      run(9'h096, 48'h4000_0000_0000, 9'h080, 48'h7FFF_FFFF_FFFF, 1'b0);
      run(9'h097, 48'h4000_0000_0000, 9'h080, 48'h7FFF_FFFF_FFFF, 1'b0);
      run(9'h080, 48'h5000_0000_0000, 9'h19E, 48'h4000_0000_0000, 1'b0);
      run(9'h090, 48'h4000_0000_0000, 9'h190, 48'h6000_0000_0000, 1'b0);
      run(9'h085, 48'h6000_0000_0000, 9'h083, 48'h4000_0000_0000, 1'b1);
      run(9'h0FF, 48'h6000_0000_0000, 9'h0FF, 48'h6000_0000_0000, 1'b0);
      run(9'h001, 48'h4000_0000_0001, 9'h001, 48'h4000_0000_0000, 1'b1);
      run(9'h088, 48'h5555_5555_5555, 9'h088, 48'h5555_5555_5555, 1'b1);
      run(9'h181, 48'h4000_0000_0000, 9'h181, 48'h4000_0000_0000, 1'b0);
      for (k = 0; k < 6; k++) begin
         rnd = {$random(seed), $random(seed)};
         run({rnd[63], 4'h8, rnd[59:56]}, {2'b01, rnd[45:0]}, {rnd[62], 4'h8, rnd[55:52]},
            {2'b01, rnd[51:46], rnd[39:0]}, rnd[61]);
      end
      test_done;
   end
endmodule
bind fasu_top fasu_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
